// >>> rtl/rcm_pkg.sv
package rcm_pkg;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_TEST = 8'h10;
    localparam logic [7:0] CMD_ACK = 8'h11;
    localparam logic [7:0] CMD_NACK = 8'h12;
    localparam logic [7:0] CMD_STOP = 8'h13;
    localparam logic [7:0] CMD_READ = 8'h31;
    localparam logic [7:0] CMD_READ_UID = 8'h35;
    localparam logic [7:0] CMD_READ_INFO = 8'h3A;
    localparam logic [7:0] CMD_READ_UID_DATA = 8'h41;
    localparam logic [7:0] CMD_EAS_ALARM = 8'h42;
    localparam logic [3:0] GENERAL_GROUP = 4'h1;

    // ----------------------------------------------------------------
    // communication modes and option byte
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_SINGLE_IMM = 4'h0;
    localparam logic [3:0] MODE_SINGLE_WAIT = 4'h1;
    localparam logic [3:0] MODE_SINGLE_REPEAT = 4'h2;
    localparam logic [3:0] MODE_EXCL_IMM = 4'h8;
    localparam logic [3:0] MODE_EXCL_WAIT = 4'h9;
    localparam logic [3:0] MODE_EXCL_CONT = 4'hA;
    localparam logic [3:0] MODE_EXCL_REPEAT = 4'hB;
    localparam logic [7:0] OPT_FIXED = 8'h20;
    localparam logic [7:0] OPT_FIXED_MASK = 8'hF0;

    // ----------------------------------------------------------------
    // end codes
    // ----------------------------------------------------------------
    localparam logic [7:0] END_OK = 8'h00;
    localparam logic [7:0] END_FORMAT = 8'h14;
    localparam logic [7:0] END_NO_TAG = 8'h72;

    // ----------------------------------------------------------------
    // host register map and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_CLR = 8'h0C;
    localparam logic [7:0] OFS_INT_EN = 8'h10;
    localparam int INT_RSP_BIT = 0;
    localparam int INT_REFUSED_BIT = 1;
    localparam int CMD_MODE_LSB = 8;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] INT_RESET = 2'h0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_WAIT_TAG = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT_ACK = 3'b011,
        ST_STOP_RSP = 3'b100
    } rcm_state_type;

    function automatic logic rcm_valid_mode(input logic [3:0] mode);
        return mode == MODE_SINGLE_IMM || mode == MODE_SINGLE_WAIT || mode == MODE_SINGLE_REPEAT
            || mode == MODE_EXCL_IMM || mode == MODE_EXCL_WAIT || mode == MODE_EXCL_CONT
            || mode == MODE_EXCL_REPEAT;
    endfunction

    function automatic logic rcm_is_read(input logic [7:0] code);
        return code == CMD_READ || code == CMD_READ_UID || code == CMD_READ_INFO
            || code == CMD_READ_UID_DATA || code == CMD_EAS_ALARM;
    endfunction

endpackage

// >>> rtl/rcm_link_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// host to device command and response link
// ----------------------------------------------------------------
interface rcm_link_if;
    logic cmdValid;
    logic [7:0] cmdCode;
    logic [7:0] cmdOption;
    logic rspValid;
    logic [7:0] rspCode;
    logic [7:0] rspData;

    modport host (
        output cmdValid,
        output cmdCode,
        output cmdOption,
        input rspValid,
        input rspCode,
        input rspData
    );

    modport device (
        input cmdValid,
        input cmdCode,
        input cmdOption,
        output rspValid,
        output rspCode,
        output rspData
    );
endinterface // rcm_link_if

// >>> rtl/rcm_device.sv
`timescale 1ns/1ns
module rcm_device (
    input wire logic clock,
    input wire logic rst_n,
    rcm_link_if.device link,
    input wire logic tagPresent,
    input wire logic tagDone,
    input wire logic [7:0] tagEndCode,
    input wire logic [7:0] tagData,
    output logic tagStart,
    output logic [7:0] tagCmd,
    output logic tagBar,
    output logic carrierOn,
    output logic asleep
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    rcm_pkg::rcm_state_type state_q, state_d;
    logic [3:0] mode_q, mode_d;
    logic [7:0] code_q, code_d;
    logic [7:0] rspCode_q, rspCode_d;
    logic [7:0] rspData_q, rspData_d;
    logic [7:0] tagCmd_q;
    logic stopPend_q, stopPend_d, carrier_q, carrier_d;
    logic rspValid_q, rspLoad, tagGo, barGo, tagStart_q, tagBar_q, asleep_q;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic isStop, isAck, isNack, isData, optOk, immediate;
    logic [3:0] optMode;

    assign optMode = link.cmdOption[3:0];
    assign isStop = link.cmdValid && link.cmdCode == rcm_pkg::CMD_STOP;
    assign isAck = link.cmdValid && link.cmdCode == rcm_pkg::CMD_ACK;
    assign isNack = link.cmdValid && link.cmdCode == rcm_pkg::CMD_NACK;
    assign isData = link.cmdValid && link.cmdCode[7:4] != rcm_pkg::GENERAL_GROUP;

    // option byte must carry the fixed bits and a defined mode
    assign optOk = (link.cmdOption & rcm_pkg::OPT_FIXED_MASK) == rcm_pkg::OPT_FIXED
        && rcm_pkg::rcm_valid_mode(optMode)
        && !(optMode == rcm_pkg::MODE_SINGLE_REPEAT && !rcm_pkg::rcm_is_read(link.cmdCode));

    assign immediate = optMode == rcm_pkg::MODE_SINGLE_IMM || optMode == rcm_pkg::MODE_EXCL_IMM;

    // ----------------------------------------------------------------
    // sequencer decisions
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        mode_d = mode_q;
        code_d = code_q;
        stopPend_d = stopPend_q;
        carrier_d = carrier_q;
        rspLoad = 1'b0;
        rspCode_d = rspCode_q;
        rspData_d = rspData_q;
        tagGo = 1'b0;
        barGo = 1'b0;
        case (state_q)
            rcm_pkg::ST_SLEEP:
            begin
                if (isStop)
                begin
                    carrier_d = 1'b0;
                    rspLoad = 1'b1;
                    rspCode_d = rcm_pkg::END_OK;
                    rspData_d = rcm_pkg::BYTE_RESET;
                end
                else if (isData)
                begin
                    code_d = link.cmdCode;
                    mode_d = optMode;
                    if (!optOk)
                    begin
                        rspLoad = 1'b1;
                        rspCode_d = rcm_pkg::END_FORMAT;
                        rspData_d = rcm_pkg::BYTE_RESET;
                    end
                    else if (immediate)
                    begin
                        if (tagPresent)
                        begin
                            tagGo = 1'b1;
                            carrier_d = 1'b1;
                            state_d = rcm_pkg::ST_EXEC;
                        end
                        else
                        begin
                            rspLoad = 1'b1;
                            rspCode_d = rcm_pkg::END_NO_TAG;
                            rspData_d = rcm_pkg::BYTE_RESET;
                        end
                    end
                    else
                    begin
                        state_d = rcm_pkg::ST_WAIT_TAG;
                    end
                end
            end
            rcm_pkg::ST_WAIT_TAG, rcm_pkg::ST_WAIT_ACK:
            begin
                if (isStop)
                begin
                    carrier_d = 1'b0;
                    rspLoad = 1'b1;
                    rspCode_d = rcm_pkg::END_OK;
                    rspData_d = rcm_pkg::BYTE_RESET;
                    state_d = rcm_pkg::ST_SLEEP;
                end
                else if (state_q == rcm_pkg::ST_WAIT_TAG && tagPresent)
                begin
                    tagGo = 1'b1;
                    carrier_d = 1'b1;
                    state_d = rcm_pkg::ST_EXEC;
                end
                else if (state_q == rcm_pkg::ST_WAIT_ACK && isAck)
                begin
                    state_d = rcm_pkg::ST_WAIT_TAG;
                end
            end
            rcm_pkg::ST_EXEC:
            begin
                if (isStop)
                begin
                    stopPend_d = 1'b1;
                end
                if (tagDone)
                begin
                    rspLoad = 1'b1;
                    rspCode_d = tagEndCode;
                    rspData_d = tagData;
                    barGo = mode_q[3];
                    if (stopPend_q || isStop)
                    begin
                        state_d = rcm_pkg::ST_STOP_RSP;
                    end
                    else
                    begin
                        case (mode_q)
                            rcm_pkg::MODE_SINGLE_REPEAT, rcm_pkg::MODE_EXCL_REPEAT:
                            begin
                                state_d = rcm_pkg::ST_WAIT_TAG;
                            end
                            rcm_pkg::MODE_EXCL_CONT:
                            begin
                                state_d = rcm_pkg::ST_WAIT_ACK;
                            end
                            rcm_pkg::MODE_EXCL_IMM, rcm_pkg::MODE_EXCL_WAIT:
                            begin
                                state_d = rcm_pkg::ST_SLEEP;
                                carrier_d = 1'b1;
                            end
                            default:
                            begin
                                state_d = rcm_pkg::ST_SLEEP;
                                carrier_d = 1'b0;
                            end
                        endcase
                    end
                end
            end
            rcm_pkg::ST_STOP_RSP:
            begin
                carrier_d = 1'b0;
                stopPend_d = 1'b0;
                rspLoad = 1'b1;
                rspCode_d = rcm_pkg::END_OK;
                rspData_d = rcm_pkg::BYTE_RESET;
                state_d = rcm_pkg::ST_SLEEP;
            end
            default:
            begin
                state_d = rcm_pkg::ST_SLEEP;
                carrier_d = 1'b0;
                stopPend_d = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= rcm_pkg::ST_SLEEP;
            mode_q <= rcm_pkg::MODE_SINGLE_IMM;
            code_q <= rcm_pkg::BYTE_RESET;
            stopPend_q <= 1'b0;
            asleep_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            mode_q <= mode_d;
            code_q <= code_d;
            stopPend_q <= stopPend_d;
            asleep_q <= state_d == rcm_pkg::ST_SLEEP;
        end
    end

    // ----------------------------------------------------------------
    // response to host; last response is kept for resend
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspValid_q <= 1'b0;
            rspCode_q <= rcm_pkg::END_OK;
            rspData_q <= rcm_pkg::BYTE_RESET;
        end
        else
        begin
            rspValid_q <= rspLoad || isNack;
            rspCode_q <= rspCode_d;
            rspData_q <= rspData_d;
        end
    end

    // ----------------------------------------------------------------
    // tag side strobes and antenna carrier
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tagStart_q <= 1'b0;
            tagCmd_q <= rcm_pkg::BYTE_RESET;
            tagBar_q <= 1'b0;
            carrier_q <= 1'b0;
        end
        else
        begin
            tagStart_q <= tagGo;
            if (tagGo)
            begin
                tagCmd_q <= code_d;
            end
            tagBar_q <= barGo;
            carrier_q <= carrier_d;
        end
    end

    assign link.rspValid = rspValid_q;
    assign link.rspCode = rspCode_q;
    assign link.rspData = rspData_q;
    assign tagStart = tagStart_q;
    assign tagCmd = tagCmd_q;
    assign tagBar = tagBar_q;
    assign carrierOn = carrier_q;
    assign asleep = asleep_q;

endmodule // rcm_device

// >>> rtl/rcm_host.sv
`timescale 1ns/1ns
module rcm_host (
    input wire logic clock,
    input wire logic rst_n,
    rcm_link_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);

    // ----------------------------------------------------------------
    // command write decode
    // ----------------------------------------------------------------
    logic cmdWr;
    logic [7:0] wCode;
    logic [3:0] wMode;
    logic general;
    logic accept;
    logic ackNeed;

    assign cmdWr = wr && addr == rcm_pkg::OFS_CMD;
    assign wCode = wdata[7:0];
    assign wMode = wdata[rcm_pkg::CMD_MODE_LSB +: 4];
    assign general = wCode[7:4] == rcm_pkg::GENERAL_GROUP;
    assign accept = general || (rcm_pkg::rcm_valid_mode(wMode)
        && !(wMode == rcm_pkg::MODE_SINGLE_REPEAT && !rcm_pkg::rcm_is_read(wCode)));

    logic cmdValid_q;
    logic [7:0] cmdCode_q;
    logic [7:0] cmdOption_q;
    logic [3:0] modeSent_q;
    logic ackPend_q;
    logic waitRsp_q;
    logic [7:0] lastCode_q;
    logic [7:0] lastData_q;
    logic [1:0] intStat_q;
    logic [1:0] intEn_q;
    logic [1:0] events;
    logic [1:0] clears;
    logic [31:0] rdata_q;
    logic irq_q;

    assign ackNeed = link.rspValid && modeSent_q == rcm_pkg::MODE_EXCL_CONT && waitRsp_q;

    // ----------------------------------------------------------------
    // link commands; software write has priority over an owed ack
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmdValid_q <= 1'b0;
            cmdCode_q <= rcm_pkg::BYTE_RESET;
            cmdOption_q <= rcm_pkg::BYTE_RESET;
            modeSent_q <= rcm_pkg::MODE_SINGLE_IMM;
            ackPend_q <= 1'b0;
        end
        else
        begin
            cmdValid_q <= 1'b0;
            if (cmdWr && accept)
            begin
                cmdValid_q <= 1'b1;
                cmdCode_q <= wCode;
                cmdOption_q <= general ? rcm_pkg::BYTE_RESET : (rcm_pkg::OPT_FIXED | {4'h0, wMode});
                if (!general)
                begin
                    modeSent_q <= wMode;
                end
                ackPend_q <= ackPend_q || ackNeed;
            end
            else if (ackPend_q || ackNeed)
            begin
                cmdValid_q <= 1'b1;
                cmdCode_q <= rcm_pkg::CMD_ACK;
                cmdOption_q <= rcm_pkg::BYTE_RESET;
                ackPend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // response capture
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitRsp_q <= 1'b0;
            lastCode_q <= rcm_pkg::BYTE_RESET;
            lastData_q <= rcm_pkg::BYTE_RESET;
        end
        else
        begin
            if (cmdWr && accept && !general)
            begin
                waitRsp_q <= 1'b1;
            end
            else if (cmdWr && wCode == rcm_pkg::CMD_STOP)
            begin
                waitRsp_q <= 1'b0;
            end
            else if (link.rspValid && modeSent_q != rcm_pkg::MODE_SINGLE_REPEAT
                && modeSent_q != rcm_pkg::MODE_EXCL_REPEAT && modeSent_q != rcm_pkg::MODE_EXCL_CONT)
            begin
                waitRsp_q <= 1'b0;
            end
            if (link.rspValid)
            begin
                lastCode_q <= link.rspCode;
                lastData_q <= link.rspData;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, enable, read port
    // ----------------------------------------------------------------
    assign events = {cmdWr && !accept, link.rspValid};
    assign clears = (wr && addr == rcm_pkg::OFS_INT_CLR) ? wdata[1:0] : 2'h0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            intStat_q <= rcm_pkg::INT_RESET;
            intEn_q <= rcm_pkg::INT_RESET;
            rdata_q <= rcm_pkg::WORD_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            intStat_q <= (intStat_q & ~clears) | events;
            if (wr && addr == rcm_pkg::OFS_INT_EN)
            begin
                intEn_q <= wdata[1:0];
            end
            irq_q <= |(intStat_q & intEn_q);
            rdata_q <= rcm_pkg::WORD_RESET;
            if (rd)
            begin
                case (addr)
                    rcm_pkg::OFS_CMD: rdata_q <= {16'h0000, 4'h0, modeSent_q, cmdCode_q};
                    rcm_pkg::OFS_STATUS: rdata_q <= {15'h0000, waitRsp_q, lastData_q, lastCode_q};
                    rcm_pkg::OFS_INT_STAT: rdata_q <= {30'h0000_0000, intStat_q};
                    rcm_pkg::OFS_INT_EN: rdata_q <= {30'h0000_0000, intEn_q};
                    default: rdata_q <= rcm_pkg::WORD_RESET;
                endcase
            end
        end
    end

    assign link.cmdValid = cmdValid_q;
    assign link.cmdCode = cmdCode_q;
    assign link.cmdOption = cmdOption_q;
    assign rdata = rdata_q;
    assign irq = irq_q;

endmodule // rcm_host

// >>> dv/rcm_link_asserts.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// link protocol checks
// ----------------------------------------------------------------
module rcm_link_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [7:0] cmdOption,
    input wire logic rspValid,
    input wire logic [7:0] rspCode,
    input wire logic [7:0] rspData
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic tagCmd;
    assign tagCmd = cmdValid && cmdCode[7:4] != 4'h1;
    a_mode_legal: assert property (tagCmd |-> cmdOption[3:0] inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB})
        else $error("illegal mode on link");
    a_opt_fixed: assert property (tagCmd |-> (cmdOption & 8'hF0) == 8'h20)
        else $error("option fixed bits wrong");
    a_ctl_opt_zero: assert property (cmdValid && !tagCmd |-> cmdOption == 8'h00)
        else $error("control command option not zero");
    a_repeat_read: assert property (tagCmd && cmdOption[3:0] == 4'h2 |->
        cmdCode inside {8'h31, 8'h35, 8'h3A, 8'h41, 8'h42})
        else $error("single repeat on non-read command");
    a_stop_answer: assert property (cmdValid && cmdCode == 8'h13 |-> ##[1:40] (rspValid && rspCode == 8'h00))
        else $error("stop not answered with end code");
    a_nack_resend: assert property (cmdValid && cmdCode == 8'h12 |=> rspValid
        && rspCode == $past(rspCode) && rspData == $past(rspData))
        else $error("negative ack did not resend");
    a_ack_silent: assert property (cmdValid && cmdCode == 8'h11 |=> !rspValid)
        else $error("ack got a response");
    a_rsp_hold: assert property (!rspValid |-> $stable(rspCode) && $stable(rspData))
        else $error("response changed without valid");
endmodule // rcm_link_asserts

// >>> dv/test_rfid_comm_mode_sequencer.sv
`timescale 1ns/1ns
module test_rfid_comm_mode_sequencer;
    logic clock = 0, rst_n = 0, wr = 0, rd = 0, tagPresent = 0, tagDone = 0;
    logic [7:0] addr = 0, tagEndCode = 8'h00, tagData = 8'hA5;
    logic [31:0] wdata = 0, d;
    wire logic [31:0] rdata;
    wire logic irq, tagStart, tagBar, carrierOn, asleep;
    wire logic [7:0] tagCmd;
    int err_count = 0, comparisons = 0, starts = 0, bars = 0, n;
    logic [20:0] rows [5] = '{{12'h031, 1'b1, 8'h00}, {12'h035, 1'b0, 8'h72}, {12'h83A, 1'b1, 8'h00},
                              {12'h141, 1'b1, 8'h00}, {12'h942, 1'b1, 8'h00}};
    rcm_link_if link();
    rcm_host rcm_host_inst (.clock(clock), .rst_n(rst_n), .link(link.host), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    rcm_device rcm_device_inst (.clock(clock), .rst_n(rst_n), .link(link.device), .tagPresent(tagPresent),
        .tagDone(tagDone), .tagEndCode(tagEndCode), .tagData(tagData), .tagStart(tagStart), .tagCmd(tagCmd),
        .tagBar(tagBar), .carrierOn(carrierOn), .asleep(asleep));
    rcm_link_asserts rcm_link_asserts_inst (.clock(clock), .rst_n(rst_n), .cmdValid(link.cmdValid),
        .cmdCode(link.cmdCode), .cmdOption(link.cmdOption), .rspValid(link.rspValid), .rspCode(link.rspCode),
        .rspData(link.rspData));
    initial forever #5 clock = ~clock;
    // tag in the field answers one cycle after each access start
    always @(posedge clock)
    begin
        tagDone <= tagStart;
        if (tagStart) starts++;
        if (tagBar) bars++;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge clock);
        wr <= 0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1;
        @(posedge clock);
        rd <= 0;
        #1 d = rdata;
    endtask
    task wait_rsp;
        n = 0;
        while (irq !== 1'b1 && n < 60)
        begin
            @(posedge clock);
            n++;
        end
        check(irq, 1);
        wr_reg(rcm_pkg::OFS_INT_CLR, 32'h0000_0003);
    endtask
    // let a stop behind a running access answer before status is cleared
    task stop_check;
        wr_reg(rcm_pkg::OFS_CMD, 32'h0000_0013);
        repeat (6) @(posedge clock);
        wait_rsp;
        check(asleep, 1);
        check(carrierOn, 0);
    endtask
    // repeating and exclusive continuous modes: several accesses, then a stop ends them
    task run_rep(input logic [31:0] cmd, input logic expBar);
        starts = 0;
        bars = 0;
        tagPresent <= 1;
        wr_reg(rcm_pkg::OFS_CMD, cmd);
        n = 0;
        while (starts < 3 && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        check(32'(starts > 2), 1);
        check(32'(tagCmd), 32'(cmd[7:0]));
        check(32'(bars != 0), 32'(expBar));
        stop_check;
        $display("test repeat %h done", cmd);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        close_out;
    end
    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1;
        wr_reg(rcm_pkg::OFS_INT_EN, 32'h0000_0001);
        for (int i = 0; i < 5; i++)
        begin
            tagPresent <= rows[i][8];
            wr_reg(rcm_pkg::OFS_CMD, {20'h0_0000, rows[i][20:9]});
            wait_rsp;
            rd_reg(rcm_pkg::OFS_STATUS);
            check(d[7:0], rows[i][7:0]);
            check(asleep, 1);
            check(carrierOn, 32'(rows[i][20]));
            stop_check;
            $display("test row %0d done", i);
        end
        run_rep(32'h0000_0231, 0);
        run_rep(32'h0000_0A31, 1);
        run_rep(32'h0000_0B35, 1);
        starts = 0;
        tagPresent <= 0;
        wr_reg(rcm_pkg::OFS_CMD, 32'h0000_0131);
        repeat (20) @(posedge clock);
        check(starts, 0);
        check(asleep, 0);
        stop_check;
        wr_reg(rcm_pkg::OFS_CMD, 32'h0000_0031);
        wait_rsp;
        wr_reg(rcm_pkg::OFS_CMD, 32'h0000_0012);
        wait_rsp;
        rd_reg(rcm_pkg::OFS_STATUS);
        check(d[7:0], 8'h72);
        $display("test wait and resend done");
        wr_reg(rcm_pkg::OFS_CMD, 32'h0000_0232);
        rd_reg(rcm_pkg::OFS_INT_STAT);
        check(d, 32'h0000_0002);
        check(irq, 0);
        wr_reg(rcm_pkg::OFS_INT_EN, 32'h0000_0003);
        @(posedge clock);
        #1 check(irq, 1);
        wr_reg(rcm_pkg::OFS_INT_CLR, 32'h0000_0002);
        rd_reg(rcm_pkg::OFS_INT_STAT);
        check(d, 32'h0000_0000);
        rd_reg(8'h40);
        check(d, 32'h0000_0000);
        $display("test refusal and registers done");
        rst_n <= 0;
        repeat (2) @(posedge clock);
        check({asleep, carrierOn, irq}, 32'h0000_0004);
        rst_n <= 1;
        rd_reg(rcm_pkg::OFS_INT_EN);
        check(d, 32'h0000_0000);
        $display("test reset done");
        close_out;
    end
endmodule // test_rfid_comm_mode_sequencer
